// ### core/dcr_pkg.sv
// constants and types of the calibration readout and loop mode block
`default_nettype none
package dcr_pkg;
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE = 3'h1;
  localparam logic [2:0] MR_THREE = 3'h3;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_LSB = 4;
  localparam int MR0_LOOP_RST_BIT = 8;
  localparam int MR1_LOOP_OFF_BIT = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR3_LOC_LSB = 0;
  localparam int MR3_READOUT_BIT = 2;
  localparam int CHOP_SELECT_ADDRESS_BIT = 12;
  localparam int NIBBLE_ADDRESS_BIT = 2;
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;
  localparam logic [4:0] READ_LATENCY_BASE = 5'h04;
  localparam logic [7:0] READOUT_PATTERN = 8'hAA;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [1:0] BL_RST = 2'h0;
  localparam logic [2:0] CL_CODE_RST = 3'h2;
  localparam logic [1:0] AL_CODE_RST = 2'h0;
  localparam int LOOP_LOCK_TIME_NCK = 512;
  typedef enum logic [1:0] {
    DCR_IDLE = 2'h0,
    DCR_WAIT = 2'h1,
    DCR_BURST = 2'h3
  } dcr_state_e;
endpackage
`default_nettype wire

// ### core/dcr_beat_if.sv
// beat stream between burst engine and output buffer
`default_nettype none
interface dcr_beat_if;
  logic valid;
  logic ready;
  logic last;
  logic [7:0] data;
  modport src (output valid, output last, output data, input ready);
  modport snk (input valid, input last, input data, output ready);
endinterface
`default_nettype wire

// ### core/dcr_sync2.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module dcr_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### core/dcr_beat_buf.sv
// two-entry skid buffer; output side is pure flip-flops
`default_nettype none
module dcr_beat_buf (
  input wire logic ref_clk,
  input wire logic srst,
  dcr_beat_if.snk beat,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);
  logic sk_valid;
  logic [7:0] sk_data;
  logic sk_last;
  logic next_out_valid;
  logic [7:0] next_out_data;
  logic next_out_last;
  logic next_sk_valid;
  logic [7:0] next_sk_data;
  logic next_sk_last;

  // ready from a flop keeps the engine off any long combinational path
  assign beat.ready = ~sk_valid;

  always_comb begin
    next_out_valid = out_valid;
    next_out_data = out_data;
    next_out_last = out_last;
    next_sk_valid = sk_valid;
    next_sk_data = sk_data;
    next_sk_last = sk_last;
    if (out_ready || !out_valid) begin
      if (sk_valid) begin
        next_out_valid = 1'b1;
        next_out_data = sk_data;
        next_out_last = sk_last;
        next_sk_valid = 1'b0;
      end else begin
        next_out_valid = beat.valid;
        next_out_data = beat.data;
        next_out_last = beat.last;
      end
    end else if (beat.valid && !sk_valid) begin
      next_sk_valid = 1'b1;
      next_sk_data = beat.data;
      next_sk_last = beat.last;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      sk_valid <= 1'b0;
      sk_data <= 8'h00;
      sk_last <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      out_last <= next_out_last;
      sk_valid <= next_sk_valid;
      sk_data <= next_sk_data;
      sk_last <= next_sk_last;
    end
  end
endmodule
`default_nettype wire

// ### core/dcr_readout.sv
// device side: command decode, mode bits, loop lock and readout bursts
`default_nettype none
module dcr_readout
  import dcr_pkg::*;
#(
  parameter int AW = 14,
  parameter int LOCK_NCK = LOOP_LOCK_TIME_NCK
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // link pins from the controller
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [AW-1:0] addr,
  // configuration
  input wire logic lanes_replicate,
  // read beat stream
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic rd_last,
  input wire logic rd_ready,
  // status
  output logic readout_mode,
  output logic loop_off,
  output logic loop_locked
);
  localparam int SW = AW + 9;
  localparam int LW = $clog2(LOCK_NCK + 1);

  logic [SW-1:0] pins_s;
  logic ck_s;
  logic cke_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic [2:0] ba_s;
  logic [AW-1:0] addr_s;
  logic ck_d;
  logic rise;
  logic cmd_mrs;
  logic cmd_read;

  dcr_sync2 #(.W(SW)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d({ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr}),
    .q(pins_s)
  );

  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s} = pins_s;
  assign rise = ck_s && !ck_d;

  // no-op and deselect fall out of the decode: neither pattern matches
  assign cmd_mrs = rise && cke_s && !cs_n_s && !ras_n_s && !cas_n_s && !we_n_s;
  assign cmd_read = rise && cke_s && !cs_n_s && ras_n_s && !cas_n_s && we_n_s;

  // ---- mode bits and loop lock ----
  logic [1:0] bl_mode;
  logic [2:0] cl_code;
  logic [1:0] al_code;
  logic [1:0] loc_sel;
  logic [LW-1:0] lock_cnt;
  logic [1:0] next_bl_mode;
  logic [2:0] next_cl_code;
  logic [1:0] next_al_code;
  logic [1:0] next_loc_sel;
  logic [LW-1:0] next_lock_cnt;
  logic next_readout_mode;
  logic next_loop_off;
  logic next_loop_locked;

  always_comb begin
    next_bl_mode = bl_mode;
    next_cl_code = cl_code;
    next_al_code = al_code;
    next_loc_sel = loc_sel;
    next_lock_cnt = lock_cnt;
    next_readout_mode = readout_mode;
    next_loop_off = loop_off;
    next_loop_locked = loop_locked;
    if (rise && lock_cnt != '0) begin
      next_lock_cnt = lock_cnt - 1'b1;
      if (lock_cnt == LW'(1)) begin
        next_loop_locked = !loop_off;
      end
    end
    if (cmd_mrs) begin
      case (ba_s)
        MR_ZERO: begin
          next_bl_mode = addr_s[MR0_BL_LSB +: 2];
          next_cl_code = addr_s[MR0_CL_LSB +: 3];
          // loop reset restarts the lock wait; only a running loop can lock
          if (addr_s[MR0_LOOP_RST_BIT] && !loop_off) begin
            next_lock_cnt = LW'(LOCK_NCK);
            next_loop_locked = 1'b0;
          end
        end
        MR_ONE: begin
          next_al_code = addr_s[MR1_AL_LSB +: 2];
          next_loop_off = addr_s[MR1_LOOP_OFF_BIT];
          if (addr_s[MR1_LOOP_OFF_BIT]) begin
            next_loop_locked = 1'b0;
            next_lock_cnt = '0;
          end
        end
        MR_THREE: begin
          next_readout_mode = addr_s[MR3_READOUT_BIT];
          next_loc_sel = addr_s[MR3_LOC_LSB +: 2];
        end
        default: begin
          next_bl_mode = bl_mode;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ck_d <= 1'b0;
      bl_mode <= BL_RST;
      cl_code <= CL_CODE_RST;
      al_code <= AL_CODE_RST;
      loc_sel <= LOC_PATTERN;
      lock_cnt <= '0;
      readout_mode <= 1'b0;
      loop_off <= 1'b0;
      loop_locked <= 1'b0;
    end else begin
      ck_d <= ck_s;
      bl_mode <= next_bl_mode;
      cl_code <= next_cl_code;
      al_code <= next_al_code;
      loc_sel <= next_loc_sel;
      lock_cnt <= next_lock_cnt;
      readout_mode <= next_readout_mode;
      loop_off <= next_loop_off;
      loop_locked <= next_loop_locked;
    end
  end

  // ---- latency ----
  logic [4:0] read_latency;
  logic [4:0] additive_latency;
  logic [5:0] lat;

  // latency in loop off mode follows the same table; 6 is the supported point
  assign read_latency = 5'({2'h0, cl_code}) + READ_LATENCY_BASE;

  always_comb begin
    case (al_code)
      2'h1: additive_latency = read_latency - 5'h01;
      2'h2: additive_latency = read_latency - 5'h02;
      default: additive_latency = 5'h00;
    endcase
  end

  // same count as an array read; loop off starts one link cycle sooner
  assign lat = 6'(additive_latency) + 6'(read_latency)
    - (loop_off ? 6'h01 : 6'h00);

  // ---- burst engine ----
  dcr_beat_if beat ();
  dcr_state_e state;
  dcr_state_e next_state;
  logic [5:0] wcnt;
  logic [2:0] idx;
  logic [2:0] end_idx;
  logic [5:0] next_wcnt;
  logic [2:0] next_idx;
  logic [2:0] next_end_idx;
  logic rd_take;
  logic chop;
  logic [2:0] start_idx;
  logic pat_bit;
  logic push;

  // reads outside readout mode belong to the array path, not to this block
  // a read landing while a burst is still pending is dropped
  assign rd_take = cmd_read && readout_mode && state == DCR_IDLE;

  always_comb begin
    case (bl_mode)
      BL_FIXED_CHOP: chop = 1'b1;
      BL_ON_THE_FLY: chop = !addr_s[CHOP_SELECT_ADDRESS_BIT];
      default: chop = 1'b0;
    endcase
  end

  // only the nibble bit matters, and only for a chopped burst
  assign start_idx = chop ? {addr_s[NIBBLE_ADDRESS_BIT], 2'h0} : 3'h0;

  // reserved locations read as zero
  assign pat_bit = (loc_sel == LOC_PATTERN) && READOUT_PATTERN[idx];

  assign beat.valid = state == DCR_BURST;
  assign beat.last = idx == end_idx;
  assign beat.data = lanes_replicate ? {8{pat_bit}} : {7'h00, pat_bit};
  assign push = beat.valid && beat.ready;

  always_comb begin
    next_state = state;
    next_wcnt = wcnt;
    next_idx = idx;
    next_end_idx = end_idx;
    case (state)
      DCR_IDLE: begin
        if (rd_take) begin
          next_state = DCR_WAIT;
          next_wcnt = lat;
          next_idx = start_idx;
          next_end_idx = start_idx + (chop ? 3'h3 : 3'h7);
        end
      end
      DCR_WAIT: begin
        if (rise) begin
          next_wcnt = wcnt - 6'h01;
          if (wcnt == 6'h01) begin
            next_state = DCR_BURST;
          end
        end
      end
      DCR_BURST: begin
        if (push) begin
          next_idx = idx + 3'h1;
          if (idx == end_idx) begin
            next_state = DCR_IDLE;
          end
        end
      end
      default: begin
        next_state = DCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= DCR_IDLE;
      wcnt <= 6'h00;
      idx <= 3'h0;
      end_idx <= 3'h0;
    end else begin
      state <= next_state;
      wcnt <= next_wcnt;
      idx <= next_idx;
      end_idx <= next_end_idx;
    end
  end

  dcr_beat_buf u_buf (
    .ref_clk(ref_clk),
    .srst(srst),
    .beat(beat.snk),
    .out_valid(rd_valid),
    .out_data(rd_data),
    .out_last(rd_last),
    .out_ready(rd_ready)
  );

  // ---- checks ----
  logic [5:0] hp_rises;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hp_rises <= 6'h00;
    end else if (rd_take) begin
      hp_rises <= 6'h00;
    end else if (rise && state == DCR_WAIT) begin
      hp_rises <= hp_rises + 6'h01;
    end
  end

  property p_nop_idle;
    @(posedge ref_clk) disable iff (srst)
    (rise && cke_s && !cs_n_s && ras_n_s && cas_n_s && we_n_s && state == DCR_IDLE)
      |=> state == DCR_IDLE;
  endproperty
  a_nop_idle: assert property (p_nop_idle) else $error("no-op started work");

  property p_deselect;
    @(posedge ref_clk) disable iff (srst)
    (rise && cs_n_s && state == DCR_IDLE) |=> state == DCR_IDLE;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect started work");

  property p_read_any_ap;
    @(posedge ref_clk) disable iff (srst)
    (cmd_read && readout_mode && state == DCR_IDLE) |=> state == DCR_WAIT && wcnt == $past(lat);
  endproperty
  a_read_any_ap: assert property (p_read_any_ap) else $error("readout read not taken");

  property p_loop_off;
    @(posedge ref_clk) disable iff (srst)
    (cmd_mrs && ba_s == MR_ONE && addr_s[MR1_LOOP_OFF_BIT]) |=> loop_off && !loop_locked;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loop off write ignored");

  property p_lanes;
    @(posedge ref_clk) disable iff (srst)
    push |-> (beat.data[7:1] == 7'h00 || beat.data[7:1] == {7{beat.data[0]}});
  endproperty
  a_lanes: assert property (p_lanes) else $error("upper lanes neither copy nor zero");

  property p_pattern;
    @(posedge ref_clk) disable iff (srst)
    (push && loc_sel == LOC_PATTERN) |-> beat.data[0] == idx[0];
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern beat wrong");

  property p_latency;
    @(posedge ref_clk) disable iff (srst)
    // judged at the supported point against the table, not against the engine's own count
    (state == DCR_BURST && $past(state) == DCR_WAIT && al_code == AL_CODE_RST
      && cl_code == CL_CODE_RST)
      |-> hp_rises == 6'(READ_LATENCY_BASE) + 6'(CL_CODE_RST) - 6'(loop_off);
  endproperty
  a_latency: assert property (p_latency) else $error("read latency wrong");

  property p_chop_high;
    @(posedge ref_clk) disable iff (srst)
    (rd_take && chop && addr_s[NIBBLE_ADDRESS_BIT]) |=> idx == 3'h4 && end_idx == 3'h7;
  endproperty
  a_chop_high: assert property (p_chop_high) else $error("upper nibble chop wrong");

  property p_last_beat;
    @(posedge ref_clk) disable iff (srst)
    (push && beat.last) |-> (idx == 3'h7 || idx == 3'h3) ##1 state == DCR_IDLE;
  endproperty
  a_last_beat: assert property (p_last_beat) else $error("burst ended off a nibble");

endmodule
`default_nettype wire

// ### test/dcr_ctrl_model.sv
// controller-side model that drives the link pins of the readout block
`default_nettype none
module dcr_ctrl_model (
  // system clock, only to keep pin changes off its rising edge
  input wire logic ref_clk,
  // link pins
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ck = 1'b0;
    // clock enable is never dropped
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    ba = 3'h0;
    addr = 14'h0000;
  end

  // one 80 ns link period per command; ck stands still between frames
  // pins change on a falling system edge so sampling never races them
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    // a deselected part has no defined bank or address: show a changing value
    ba = c[3] ? ~ba : b;
    addr = c[3] ? ~addr : a;
    #43;
    ck = 1'b1;
    #35;
    ck = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the calibration readout and loop mode block
`default_nettype none
module tb
  import dcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [3:0] CMD_MODE = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'h8;

  logic ref_clk, srst, lanes_replicate, rd_ready;
  logic ck, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic rd_valid, rd_last, readout_mode, loop_off, loop_locked;
  logic [7:0] rd_data;
  logic [7:0] dq[$];
  logic lq[$];
  int errors = 0;
  int checks = 0;

  dcr_ctrl_model dcr_ctrl_model_i (.ref_clk(ref_clk), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

  dcr_readout #(.AW(14), .LOCK_NCK(8)) dcr_readout_i (.ref_clk(ref_clk), .srst(srst),
    .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .lanes_replicate(lanes_replicate), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_last(rd_last), .rd_ready(rd_ready),
    .readout_mode(readout_mode), .loop_off(loop_off), .loop_locked(loop_locked));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // collect every beat the receiver takes
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      dq.push_back(rd_data);
      lq.push_back(rd_last);
    end
  end

  task automatic summarize();
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic nops(input int n, input logic [3:0] c);
    repeat (n) dcr_ctrl_model_i.cmd(c, 3'h0, 14'h0000);
  endtask

  // mode writes are only legal with readout off, so each one is wrapped
  task automatic mrs_wrap(input logic [2:0] b, input logic [13:0] a);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0000);
    dcr_ctrl_model_i.cmd(CMD_MODE, b, a);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0004);
  endtask

  // read with stray bank, precharge and column bits; checks nothing shows early
  task automatic rd_go(input logic a12, input logic a2, input logic [2:0] b,
      input int lat, input logic des);
    dq.delete();
    lq.delete();
    dcr_ctrl_model_i.cmd(CMD_READ, b, {1'b0, a12, 1'b0, 1'b1, 7'h5A, a2, 2'h0});
    nops(lat - 1, des ? CMD_DESEL : CMD_NOP);
    @(negedge ref_clk);
    chk1("valid before latency", 1'b0, rd_valid);
    nops(1, CMD_NOP);
  endtask

  task automatic burst(input int n, input int st, input logic rsv, input logic rep);
    int i;
    logic b;
    i = 0;
    while (i < 80 && !(lq.size() > 0 && lq[$] === 1'b1)) begin
      @(posedge ref_clk);
      i++;
    end
    if (i == 80) begin
      errors++;
      summarize();
    end
    chk8("beat count", 8'(n), 8'(dq.size()));
    for (i = 0; i < dq.size(); i++) begin
      b = rsv ? 1'b0 : READOUT_PATTERN[st + i];
      chk8("beat data", rep ? {8{b}} : {7'h00, b}, dq[i]);
      chk1("beat last", i == dq.size() - 1, lq[i]);
    end
  endtask

  initial begin
    srst = 1'b1;
    lanes_replicate = 1'b0;
    rd_ready = 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk1("readout after reset", 1'b0, readout_mode);
    chk1("loop off after reset", 1'b0, loop_off);
    chk1("locked after reset", 1'b0, loop_locked);
    // latency code 2 (six), fixed eight beats, loop reset
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_ZERO, 14'h0120);
    nops(7, CMD_NOP);
    @(negedge ref_clk);
    chk1("locked too early", 1'b0, loop_locked);
    nops(1, CMD_NOP);
    @(negedge ref_clk);
    chk1("locked", 1'b1, loop_locked);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0004);
    @(negedge ref_clk);
    chk1("readout on", 1'b1, readout_mode);
    rd_go(1'b0, 1'b0, 3'h7, 6, 1'b0);
    burst(8, 0, 1'b0, 1'b0);
    // deselects fill the wait up to its last cycle; receiver stalls until the burst has started
    @(posedge ref_clk);
    lanes_replicate <= 1'b1;
    rd_ready <= 1'b0;
    rd_go(1'b0, 1'b0, 3'h2, 6, 1'b1);
    repeat (20) @(negedge ref_clk);
    chk1("stalled valid", 1'b1, rd_valid);
    @(posedge ref_clk);
    rd_ready <= 1'b1;
    burst(8, 0, 1'b0, 1'b1);
    mrs_wrap(MR_ZERO, 14'h0022);
    rd_go(1'b1, 1'b0, 3'h1, 6, 1'b0);
    burst(4, 0, 1'b0, 1'b1);
    rd_go(1'b1, 1'b1, 3'h5, 6, 1'b0);
    burst(4, 4, 1'b0, 1'b1);
    mrs_wrap(MR_ZERO, 14'h0021);
    rd_go(1'b1, 1'b0, 3'h4, 6, 1'b0);
    burst(8, 0, 1'b0, 1'b1);
    rd_go(1'b0, 1'b1, 3'h6, 6, 1'b0);
    burst(4, 4, 1'b0, 1'b1);
    // reserved location: chosen behaviour is all-zero beats
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0005);
    rd_go(1'b1, 1'b0, 3'h0, 6, 1'b0);
    burst(8, 0, 1'b1, 1'b1);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0004);
    // the deselect shows a clear of register three on a mode-set code; a no-op aims there too
    dcr_ctrl_model_i.cmd(CMD_NOP, 3'h4, 14'h3FFF);
    nops(1, CMD_DESEL);
    dcr_ctrl_model_i.cmd(CMD_NOP, MR_THREE, 14'h0000);
    @(negedge ref_clk);
    chk1("readout kept", 1'b1, readout_mode);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0000);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_ONE, 14'h0001);
    @(negedge ref_clk);
    chk1("loop off", 1'b1, loop_off);
    chk1("unlocked when off", 1'b0, loop_locked);
    // stand-in for the mode-set wait and the self refresh stay
    nops(4, CMD_DESEL);
    mrs_wrap(MR_ZERO, 14'h0021);
    @(negedge ref_clk);
    chk1("loop stays off", 1'b1, loop_off);
    rd_go(1'b1, 1'b0, 3'h3, 5, 1'b0);
    burst(8, 0, 1'b0, 1'b1);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_THREE, 14'h0000);
    @(negedge ref_clk);
    chk1("readout off", 1'b0, readout_mode);
    rd_go(1'b1, 1'b0, 3'h0, 6, 1'b0);
    repeat (30) @(negedge ref_clk);
    chk8("beats with readout off", 8'h00, 8'(dq.size()));
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_ONE, 14'h0000);
    dcr_ctrl_model_i.cmd(CMD_MODE, MR_ZERO, 14'h0120);
    @(negedge ref_clk);
    chk1("loop on", 1'b0, loop_off);
    nops(8, CMD_NOP);
    @(negedge ref_clk);
    chk1("relocked", 1'b1, loop_locked);
    summarize();
  end
endmodule
`default_nettype wire
